// ---- rtl/dff_defines.svh ----
/*
 Widths, register offsets, field positions and reset values
 of the storage element family.
 Assumes inclusion by bare name from package and modules.
*/
`ifndef DFF_DEFINES_SVH
`define DFF_DEFINES_SVH

`define DFF_WIDE_W       16
`define DFF_NARROW_W     4
`define DFF_BUS_AW       8
`define DFF_BUS_DW       32
`define DFF_REG_CTRL     8'h00
`define DFF_REG_WIDE     8'h04
`define DFF_REG_NARROW   8'h08
`define DFF_CTRL_W       2
`define DFF_CTRL_INV_BIT 0
`define DFF_CTRL_SW_BIT  1
`define DFF_CTRL_RST     2'h0
`define DFF_RDATA_RST    32'h0000_0000
`define DFF_INIT_DEF     1'b0
`define DFF_NARROW_PAD   22

`endif

// ---- rtl/dff_pkg.sv ----
/*
 Types shared by the storage element family.
 Assumes the defines header sits beside it.
*/
`include "dff_defines.svh"

package dff_pkg;

	typedef enum logic [1:0]
	{
		DFF_EDGE_RISE = 2'b01,
		DFF_EDGE_FALL = 2'b10
	} dff_edge_type;

	typedef enum logic [1:0]
	{
		DFF_RST_CLEAR = 2'b01,
		DFF_RST_SYNC  = 2'b10
	} dff_rst_type;

	typedef struct packed
	{
		logic [`DFF_CTRL_W-1:0]  ctrl;
		logic [`DFF_BUS_DW-1:0]  rdata;
	} dff_top_state_type;

endpackage : dff_pkg

// ---- rtl/dff_bit_store.sv ----
/*
 One-bit D flip-flop, capturing on the rising or falling
 clock edge. Assumes rst_n already merges power-on and
 global set/reset.
*/
`timescale 1ns/1ps
`include "dff_defines.svh"

module dff_bit_store #(
	parameter dff_pkg::dff_edge_type EDGE = dff_pkg::DFF_EDGE_RISE,
	parameter logic                  INIT = `DFF_INIT_DEF
)(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	import dff_pkg::*;

	typedef struct packed
	{
		logic q;
	} dff_bit_state_type;

	dff_bit_state_type state_q;
	dff_bit_state_type state_d;

	always_comb
	begin
		state_d.q = d;
	end

	generate
		if (EDGE == DFF_EDGE_FALL)
		begin : g_fall
			always_ff @(negedge clk or negedge rst_n)
			begin
				if (!rst_n)
					state_q <= INIT;
				else
					state_q <= state_d;
			end
		end
		else
		begin : g_rise
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					state_q <= INIT;
				else
					state_q <= state_d;
			end
		end
	endgenerate

	assign q = state_q.q;

endmodule : dff_bit_store

// ---- rtl/dff_data_reg.sv ----
/*
 Data register with clock enable and either asynchronous
 clear (through rst_n) or synchronous reset (srst).
 Assumes the owner folds any asynchronous clear into rst_n.
*/
`timescale 1ns/1ps
`include "dff_defines.svh"

module dff_data_reg #(
	parameter int                   WIDTH = `DFF_NARROW_W,
	parameter dff_pkg::dff_rst_type STYLE = dff_pkg::DFF_RST_CLEAR
)(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	import dff_pkg::*;

	typedef struct packed
	{
		logic [WIDTH-1:0] q;
	} dff_reg_state_type;

	dff_reg_state_type state_q;
	dff_reg_state_type state_d;

	always_comb
	begin
		state_d = state_q;
		if (STYLE == DFF_RST_SYNC && srst)
			state_d.q = '0;
		else if (ce)
			state_d.q = d;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign q = state_q.q;

endmodule : dff_data_reg

// ---- rtl/dff_family.sv ----
/*
 Storage element family: rising and falling one-bit
 flip-flops, 16-bit and 4-bit registers with clock enable
 and asynchronous clear or synchronous reset, plus a small
 software port for global set/reset control and readback.
 Assumes all inputs are synchronous to MCLK, except the
 asynchronous clears, global set/reset and RST_N.
*/
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "dff_defines.svh"

// How it works
// - The rising one-bit element copies its input at each rising edge.
// - The falling one-bit element copies its input at each falling edge.
// - Each one-bit element has an initial value of 0 or 1, default 0.
// - At power-up the registers read low and each one-bit element reads its initial value before any clock edge.
// - Global set/reset acts as power-on, high active unless inverted.
// - The clear register loads its data when enabled and not cleared.
// - A high asynchronous clear forces the outputs low at once.
// - With enable low and no clear or reset, the outputs hold.
// - A high synchronous reset zeroes the outputs at a rising edge.
// - The reset register loads its data when enabled and not reset.
// - The wide registers hold sixteen bits each.
// - The narrow registers hold four bits each.
// - Each output bit takes the data bit of the same index.
module dff_family #(
	parameter logic RISE_INIT = `DFF_INIT_DEF,
	parameter logic FALL_INIT = `DFF_INIT_DEF
)(
	input  wire logic                     MCLK,
	input  wire logic                     RST_N,
	input  wire logic                     GLOBAL_SET_RESET,
	input  wire logic                     RISE_D,
	output logic                          RISE_Q,
	input  wire logic                     FALL_D,
	output logic                          FALL_Q,
	input  wire logic                     WC_CE,
	input  wire logic                     WC_ASYNC_CLEAR_IN,
	input  wire logic [`DFF_WIDE_W-1:0]   WC_D,
	output logic      [`DFF_WIDE_W-1:0]   WC_Q,
	input  wire logic                     WS_CE,
	input  wire logic                     WS_SYNC_RESET,
	input  wire logic [`DFF_WIDE_W-1:0]   WS_D,
	output logic      [`DFF_WIDE_W-1:0]   WS_Q,
	input  wire logic                     NC_CE,
	input  wire logic                     NC_ASYNC_CLEAR_IN,
	input  wire logic [`DFF_NARROW_W-1:0] NC_D,
	output logic      [`DFF_NARROW_W-1:0] NC_Q,
	input  wire logic                     NS_CE,
	input  wire logic                     NS_SYNC_RESET,
	input  wire logic [`DFF_NARROW_W-1:0] NS_D,
	output logic      [`DFF_NARROW_W-1:0] NS_Q,
	input  wire logic [`DFF_BUS_AW-1:0]   ADDR,
	input  wire logic [`DFF_BUS_DW-1:0]   WR_DATA,
	input  wire logic                     WR_STB,
	input  wire logic                     RD_STB,
	output logic      [`DFF_BUS_DW-1:0]   RD_DATA
);
	import dff_pkg::*;

	dff_top_state_type state_q;
	dff_top_state_type state_d;

	logic gsr_on;
	logic elem_rst_n;
	logic wc_rst_n;
	logic nc_rst_n;

	assign gsr_on = (GLOBAL_SET_RESET
		^ state_q.ctrl[`DFF_CTRL_INV_BIT])
		| state_q.ctrl[`DFF_CTRL_SW_BIT];

	// power-on and global set/reset clear the registers and load INIT into the one-bit elements
	assign elem_rst_n = RST_N & ~gsr_on;

	assign wc_rst_n = elem_rst_n & ~WC_ASYNC_CLEAR_IN;
	assign nc_rst_n = elem_rst_n & ~NC_ASYNC_CLEAR_IN;

	dff_bit_store #(
		.EDGE (DFF_EDGE_RISE),
		.INIT (RISE_INIT)
	) rising_edge_bit_store (
		.clk   (MCLK),
		.rst_n (elem_rst_n),
		.d     (RISE_D),
		.q     (RISE_Q)
	);

	// same element on the falling edge
	dff_bit_store #(
		.EDGE (DFF_EDGE_FALL),
		.INIT (FALL_INIT)
	) falling_edge_bit_store (
		.clk   (MCLK),
		.rst_n (elem_rst_n),
		.d     (FALL_D),
		.q     (FALL_Q)
	);

	dff_data_reg #(
		.WIDTH (`DFF_WIDE_W),
		.STYLE (DFF_RST_CLEAR)
	) wide_register_with_clear (
		.clk   (MCLK),
		.rst_n (wc_rst_n),
		.ce    (WC_CE),
		.srst  (1'b0),
		.d     (WC_D),
		.q     (WC_Q)
	);

	dff_data_reg #(
		.WIDTH (`DFF_WIDE_W),
		.STYLE (DFF_RST_SYNC)
	) wide_register_with_sync_reset (
		.clk   (MCLK),
		.rst_n (elem_rst_n),
		.ce    (WS_CE),
		.srst  (WS_SYNC_RESET),
		.d     (WS_D),
		.q     (WS_Q)
	);

	dff_data_reg #(
		.WIDTH (`DFF_NARROW_W),
		.STYLE (DFF_RST_CLEAR)
	) narrow_register_with_clear (
		.clk   (MCLK),
		.rst_n (nc_rst_n),
		.ce    (NC_CE),
		.srst  (1'b0),
		.d     (NC_D),
		.q     (NC_Q)
	);

	dff_data_reg #(
		.WIDTH (`DFF_NARROW_W),
		.STYLE (DFF_RST_SYNC)
	) narrow_register_with_sync_reset (
		.clk   (MCLK),
		.rst_n (elem_rst_n),
		.ce    (NS_CE),
		.srst  (NS_SYNC_RESET),
		.d     (NS_D),
		.q     (NS_Q)
	);

	// register port: data only in the cycle after a read
	always_comb
	begin
		state_d       = state_q;
		state_d.rdata = `DFF_RDATA_RST;
		if (WR_STB && ADDR == `DFF_REG_CTRL)
			state_d.ctrl = WR_DATA[`DFF_CTRL_W-1:0];
		if (RD_STB)
		begin
			case (ADDR)
				`DFF_REG_CTRL:
					state_d.rdata = {{(`DFF_BUS_DW-`DFF_CTRL_W){1'b0}},
						state_q.ctrl};
				`DFF_REG_WIDE:
					state_d.rdata = {WS_Q, WC_Q};
				`DFF_REG_NARROW:
					state_d.rdata = {{`DFF_NARROW_PAD{1'b0}},
						FALL_Q, RISE_Q, NS_Q, NC_Q};
				default:
					state_d.rdata = `DFF_RDATA_RST;
			endcase
		end
	end

	// control register survives software set/reset, so it can clear it
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_q.ctrl  <= `DFF_CTRL_RST;
			state_q.rdata <= `DFF_RDATA_RST;
		end
		else
			state_q <= state_d;
	end

	assign RD_DATA = state_q.rdata;

	// checks; clocked on MCLK, off while RST_N is low
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	logic quiet;
	assign quiet = ~gsr_on;

	sequence s_quiet2;
		quiet ##1 quiet;
	endsequence

	sequence s_wc_load;
		quiet && !WC_ASYNC_CLEAR_IN && WC_CE
			##1 quiet && !WC_ASYNC_CLEAR_IN;
	endsequence

	sequence s_ws_load;
		quiet && !WS_SYNC_RESET && WS_CE ##1 quiet;
	endsequence

	property p_rise_cap;
		s_quiet2 |-> RISE_Q == $past(RISE_D);
	endproperty
	a_rise_cap: assert property (p_rise_cap)
		else $error("rising bit did not capture");

	property p_fall_cap;
		@(negedge MCLK) disable iff (!RST_N)
		quiet ##1 quiet |-> FALL_Q == $past(FALL_D);
	endproperty
	a_fall_cap: assert property (p_fall_cap)
		else $error("falling bit did not capture");

	property p_init_val;
		gsr_on |-> RISE_Q == RISE_INIT && FALL_Q == FALL_INIT;
	endproperty
	a_init_val: assert property (p_init_val)
		else $error("one-bit element not at initial value");

	property p_gsr_clear;
		gsr_on |-> WC_Q == '0 && WS_Q == '0
			&& NC_Q == '0 && NS_Q == '0;
	endproperty
	a_gsr_clear: assert property (p_gsr_clear)
		else $error("register not clear under set/reset");

	property p_sw_gsr;
		WR_STB && ADDR == `DFF_REG_CTRL
			&& WR_DATA[`DFF_CTRL_SW_BIT] |=> gsr_on;
	endproperty
	a_sw_gsr: assert property (p_sw_gsr)
		else $error("software set/reset not applied");

	property p_wc_load;
		s_wc_load |-> WC_Q == $past(WC_D);
	endproperty
	a_wc_load: assert property (p_wc_load)
		else $error("wide clear register missed a load");

	property p_nc_load;
		quiet && !NC_ASYNC_CLEAR_IN && NC_CE
			##1 quiet && !NC_ASYNC_CLEAR_IN
			|-> NC_Q == $past(NC_D);
	endproperty
	a_nc_load: assert property (p_nc_load)
		else $error("narrow clear register bit mismatch");

	property p_async_clr;
		WC_ASYNC_CLEAR_IN || NC_ASYNC_CLEAR_IN
			|-> (!WC_ASYNC_CLEAR_IN || WC_Q == '0)
			&& (!NC_ASYNC_CLEAR_IN || NC_Q == '0);
	endproperty
	a_async_clr: assert property (p_async_clr)
		else $error("asynchronous clear not obeyed");

	property p_hold;
		quiet && !WC_CE && !WS_CE && !WS_SYNC_RESET
			&& !WC_ASYNC_CLEAR_IN
			##1 quiet && !WC_ASYNC_CLEAR_IN
			|-> $stable(WC_Q) && $stable(WS_Q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("register changed without enable");

	property p_sync_rst;
		quiet && (WS_SYNC_RESET || NS_SYNC_RESET) ##1 quiet
			|-> (!$past(WS_SYNC_RESET) || WS_Q == '0)
			&& (!$past(NS_SYNC_RESET) || NS_Q == '0);
	endproperty
	a_sync_rst: assert property (p_sync_rst)
		else $error("synchronous reset did not clear");

	property p_sync_wait;
		s_quiet2 ##0 WS_SYNC_RESET && !$past(WS_SYNC_RESET)
			&& $past(WS_Q) != '0 && !$past(WS_CE)
			|-> WS_Q == $past(WS_Q);
	endproperty
	a_sync_wait: assert property (p_sync_wait)
		else $error("synchronous reset acted early");

	property p_ws_load;
		s_ws_load |-> WS_Q == $past(WS_D);
	endproperty
	a_ws_load: assert property (p_ws_load)
		else $error("wide reset register missed a load");

	property p_ns_load;
		quiet && !NS_SYNC_RESET && NS_CE ##1 quiet
			|-> NS_Q == $past(NS_D);
	endproperty
	a_ns_load: assert property (p_ns_load)
		else $error("narrow reset register missed a load");

	property p_rd_wide;
		RD_STB && ADDR == `DFF_REG_WIDE
			|=> RD_DATA == $past({WS_Q, WC_Q});
	endproperty
	a_rd_wide: assert property (p_rd_wide)
		else $error("wide readback wrong");

	property p_rd_narrow;
		RD_STB && ADDR == `DFF_REG_NARROW
			|=> RD_DATA == $past({{`DFF_NARROW_PAD{1'b0}},
				FALL_Q, RISE_Q, NS_Q, NC_Q});
	endproperty
	a_rd_narrow: assert property (p_rd_narrow)
		else $error("narrow readback wrong");

	property p_ctrl_wr;
		WR_STB && ADDR == `DFF_REG_CTRL
			|=> state_q.ctrl == $past(WR_DATA[`DFF_CTRL_W-1:0]);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr)
		else $error("control write did not land");

	property p_ctrl_keep;
		!(WR_STB && ADDR == `DFF_REG_CTRL)
			|=> $stable(state_q.ctrl);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep)
		else $error("control changed without a write");

	property p_ns_hold;
		quiet && !NS_CE && !NS_SYNC_RESET && !NC_CE
			&& !NC_ASYNC_CLEAR_IN
			##1 quiet && !NC_ASYNC_CLEAR_IN
			|-> $stable(NS_Q) && $stable(NC_Q);
	endproperty
	a_ns_hold: assert property (p_ns_hold)
		else $error("narrow register changed without enable");

	property p_rd_idle;
		!RD_STB |=> RD_DATA == `DFF_RDATA_RST;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read answer");

endmodule : dff_family

// ---- tb/tb_dff_family.sv ----
/*
 Self-checking bench for the storage element family.
 Assumes the rtl defines header, package and modules compile first.
*/
`timescale 1ns/1ps
`include "dff_defines.svh"

module tb_dff_family;
	import dff_pkg::*;

	logic                     MCLK, RST_N, GLOBAL_SET_RESET;
	logic                     RISE_D, RISE_Q, FALL_D, FALL_Q;
	logic                     WC_CE, WC_ASYNC_CLEAR_IN, WS_CE, WS_SYNC_RESET;
	logic                     NC_CE, NC_ASYNC_CLEAR_IN, NS_CE, NS_SYNC_RESET;
	logic [`DFF_WIDE_W-1:0]   WC_D, WC_Q, WS_D, WS_Q;
	logic [`DFF_NARROW_W-1:0] NC_D, NC_Q, NS_D, NS_Q;
	logic [`DFF_BUS_AW-1:0]   ADDR;
	logic [`DFF_BUS_DW-1:0]   WR_DATA, RD_DATA, rd_v;
	logic                     WR_STB, RD_STB;
	int                       mismatches;
	int                       n_checks;

	dff_family dff_family_i (.MCLK(MCLK), .RST_N(RST_N),
		.GLOBAL_SET_RESET(GLOBAL_SET_RESET), .RISE_D(RISE_D),
		.RISE_Q(RISE_Q), .FALL_D(FALL_D), .FALL_Q(FALL_Q),
		.WC_CE(WC_CE), .WC_ASYNC_CLEAR_IN(WC_ASYNC_CLEAR_IN),
		.WC_D(WC_D), .WC_Q(WC_Q), .WS_CE(WS_CE),
		.WS_SYNC_RESET(WS_SYNC_RESET), .WS_D(WS_D), .WS_Q(WS_Q),
		.NC_CE(NC_CE), .NC_ASYNC_CLEAR_IN(NC_ASYNC_CLEAR_IN),
		.NC_D(NC_D), .NC_Q(NC_Q), .NS_CE(NS_CE),
		.NS_SYNC_RESET(NS_SYNC_RESET), .NS_D(NS_D), .NS_Q(NS_Q),
		.ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
		.RD_STB(RD_STB), .RD_DATA(RD_DATA));

	initial
	begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_all(input logic [15:0] w, input logic [3:0] n,
		input logic b);
		chk("wc_q", {16'h0, w}, {16'h0, WC_Q});
		chk("ws_q", {16'h0, w}, {16'h0, WS_Q});
		chk("nc_q", {28'h0, n}, {28'h0, NC_Q});
		chk("ns_q", {28'h0, n}, {28'h0, NS_Q});
		chk("rise_q", {31'h0, b}, {31'h0, RISE_Q});
		chk("fall_q", {31'h0, b}, {31'h0, FALL_Q});
	endtask : chk_all

	task automatic set_ce(input logic v);
		WC_CE <= v;
		WS_CE <= v;
		NC_CE <= v;
		NS_CE <= v;
	endtask : set_ce

	task automatic load_all(input logic [15:0] w, input logic [3:0] n,
		input logic b);
		@(posedge MCLK);
		set_ce(1'b1);
		WC_D <= w;
		WS_D <= w;
		NC_D <= n;
		NS_D <= n;
		RISE_D <= b;
		FALL_D <= b;
		@(posedge MCLK);
		set_ce(1'b0);
		#1;
	endtask : load_all

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge MCLK);
		WR_STB <= 1'b1;
		ADDR <= a;
		WR_DATA <= v;
		@(posedge MCLK);
		WR_STB <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a);
		@(posedge MCLK);
		RD_STB <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD_STB <= 1'b0;
		#1 rd_v = RD_DATA;
	endtask : bus_rd

	// rising bit must wait for the rising edge, falling bit for the falling
	task automatic t_bits;
		for (int i = 1; i >= 0; i--)
		begin
			@(posedge MCLK);
			RISE_D <= i[0];
			FALL_D <= i[0];
			@(negedge MCLK);
			#1 chk("fall_q", i, {31'h0, FALL_Q});
			chk("rise_q", {31'h0, ~i[0]}, {31'h0, RISE_Q});
			@(posedge MCLK);
			#1 chk("rise_q", i, {31'h0, RISE_Q});
		end
	endtask : t_bits

	task automatic t_clear_regs;
		load_all(16'hA5C3, 4'h9, 1'b0);
		chk("wc_q", 32'h0000A5C3, {16'h0, WC_Q});
		chk("nc_q", 32'h00000009, {28'h0, NC_Q});
		WC_D <= 16'h5A3C;
		NC_D <= 4'h6;
		@(posedge MCLK);
		#1 chk("wc_q", 32'h0000A5C3, {16'h0, WC_Q});
		chk("nc_q", 32'h00000009, {28'h0, NC_Q});
		@(posedge MCLK);
		set_ce(1'b1);
		WC_ASYNC_CLEAR_IN <= 1'b1;
		NC_ASYNC_CLEAR_IN <= 1'b1;
		#1 chk("wc_q", 32'h0, {16'h0, WC_Q});
		chk("nc_q", 32'h0, {28'h0, NC_Q});
		@(posedge MCLK);
		#1 chk("wc_q", 32'h0, {16'h0, WC_Q});
		WC_ASYNC_CLEAR_IN <= 1'b0;
		NC_ASYNC_CLEAR_IN <= 1'b0;
		set_ce(1'b0);
	endtask : t_clear_regs

	// reset is clocked: nothing changes until the edge, even with CE driven high
	task automatic t_sync_regs;
		load_all(16'h1234, 4'hB, 1'b1);
		chk("ws_q", 32'h00001234, {16'h0, WS_Q});
		chk("ns_q", 32'h0000000B, {28'h0, NS_Q});
		@(posedge MCLK);
		set_ce(1'b1);
		WS_D <= 16'hFFFF;
		NS_D <= 4'hF;
		WS_SYNC_RESET <= 1'b1;
		NS_SYNC_RESET <= 1'b1;
		#1 chk("ws_q", 32'h00001234, {16'h0, WS_Q});
		chk("ns_q", 32'h0000000B, {28'h0, NS_Q});
		@(posedge MCLK);
		#1 chk("ws_q", 32'h0, {16'h0, WS_Q});
		chk("ns_q", 32'h0, {28'h0, NS_Q});
		WS_SYNC_RESET <= 1'b0;
		NS_SYNC_RESET <= 1'b0;
		set_ce(1'b0);
	endtask : t_sync_regs

	task automatic t_global;
		load_all(16'hF00D, 4'h7, 1'b1);
		bus_rd(`DFF_REG_WIDE);
		chk("rd_wide", 32'hF00DF00D, rd_v);
		bus_rd(`DFF_REG_NARROW);
		chk("rd_narrow", 32'h00000377, rd_v);
		bus_rd(8'h0C);
		chk("rd_unmapped", 32'h0, rd_v);
		@(posedge MCLK);
		GLOBAL_SET_RESET <= 1'b1;
		#1 chk_all(16'h0, 4'h0, 1'b0);
		@(posedge MCLK);
		GLOBAL_SET_RESET <= 1'b0;
		load_all(16'h8001, 4'h8, 1'b1);
		chk_all(16'h8001, 4'h8, 1'b1);
		bus_wr(`DFF_REG_CTRL, 32'h1);
		#1 chk_all(16'h0, 4'h0, 1'b0);
		bus_rd(`DFF_REG_CTRL);
		chk("rd_ctrl", 32'h1, rd_v);
		GLOBAL_SET_RESET <= 1'b1;
		load_all(16'h0F0F, 4'h5, 1'b1);
		chk_all(16'h0F0F, 4'h5, 1'b1);
		bus_wr(`DFF_REG_CTRL, 32'h3);
		#1 chk_all(16'h0, 4'h0, 1'b0);
		bus_wr(`DFF_REG_CTRL, 32'h0);
		GLOBAL_SET_RESET <= 1'b0;
	endtask : t_global

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	initial
	begin
		#(5000 * 50);
		mismatches++;
		complete_run();
	end

	initial
	begin
		mismatches = 0;
		n_checks = 0;
		{RST_N, GLOBAL_SET_RESET, RISE_D, FALL_D} = 4'h0;
		{WC_CE, WC_ASYNC_CLEAR_IN, WS_CE, WS_SYNC_RESET} = 4'h0;
		{NC_CE, NC_ASYNC_CLEAR_IN, NS_CE, NS_SYNC_RESET} = 4'h0;
		{WC_D, WS_D, NC_D, NS_D} = 40'h0;
		{ADDR, WR_DATA, WR_STB, RD_STB} = 42'h0;
		repeat (16) @(posedge MCLK);
		#1 chk_all(16'h0, 4'h0, 1'b0);
		chk("rd_data", 32'h0, RD_DATA);
		@(posedge MCLK);
		RST_N <= 1'b1;
		t_bits();
		t_clear_regs();
		t_sync_regs();
		t_global();
		complete_run();
	end
endmodule : tb_dff_family
